/* File: nvpm_regs.svh */
// Constants for the nonvolatile parameter memory link
// What this block does
// - 256 by 4 volatile array, nonvolatile backing copy
// - Power-up initialize recalls nonvolatile into volatile
// - Processor writes alter volatile only until store
// - Store strobe needs store select and bit8 low
// - Power-down sensed suppresses the store strobe
// - Chip select needs select and column strobe low
// - Read-high with select selects location bits 1-8
// - Write same as read with read-high low
`ifndef NVPM_REGS_SVH
`define NVPM_REGS_SVH
`define NVPM_DEPTH 256
`define NVPM_AW 8
`define NVPM_DW 4
`define NVPM_BUS_W 8
`define NVPM_INIT_WORD 4'h0
`endif

/* File: nvpm_pkg.sv */
// Types shared by both ends of the parameter memory link
package nvpm_pkg;
  // Device sequencer states
  typedef enum logic [1:0] {NVPM_IDLE, NVPM_RECALL, NVPM_STORE} nvpm_state_e;
endpackage

/* File: nvpm_if.sv */
// Interface joining the processor end to the parameter memory
`timescale 1ns/1ps
`include "nvpm_regs.svh"
interface nvpm_if;
  logic param_mem_select_n; // Decoded memory select
  logic column_strobe_n; // Processor column strobe
  logic store_select_n; // Decoded store select
  logic read_high; // High for reads, low for writes
  logic [`NVPM_AW:1] latched_addr_bits; // Address bits 1 to 8
  logic [`NVPM_BUS_W-1:0] host_data; // Data driven by processor
  logic [`NVPM_BUS_W-1:0] dev_data; // Data driven by device
  logic dev_data_oe_n; // Device drives bus when low
  logic power_down; // Power-down sensed, high active
  logic init_n; // Power-up initialize, low active
  logic busy; // Device recalling or storing
  modport device (input param_mem_select_n, column_strobe_n, store_select_n, read_high, latched_addr_bits,
    host_data, power_down, init_n, output dev_data, dev_data_oe_n, busy);
  modport host (output param_mem_select_n, column_strobe_n, store_select_n, read_high, latched_addr_bits,
    host_data, power_down, init_n, input dev_data, dev_data_oe_n, busy);
endinterface

/* File: nvpm_device.sv */
// Parameter memory device: volatile array, backing array, recall and store
`timescale 1ns/1ps
`include "nvpm_regs.svh"
module nvpm_device
  import nvpm_pkg::*;
#(
  parameter int DEPTH = `NVPM_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  nvpm_if.device link,
  output logic recall_done_ff,
  output logic store_done_ff
);

  // Timing in brief: a host access is taken on the edge where select and
  // strobe are both low; a read answers on the following cycle for one
  // cycle only. A recall or a store moves one word per clock, so a recall or
  // a store not cut by power-down keeps the array busy for DEPTH cycles and host access waits.

  // Storage
  logic [`NVPM_DW-1:0] vol_mem [DEPTH]; // Volatile array, host visible
  logic [`NVPM_DW-1:0] nv_mem [DEPTH]; // Nonvolatile array, reached only by copies
  wire [DEPTH-1:0] nv_prog; // Backing word has been programmed at least once

  // Sequencer registers and their next values
  nvpm_state_e state_ff; // Current copy state
  nvpm_state_e nxt_state; // Next copy state
  logic [`NVPM_AW-1:0] idx_ff; // Word the copy is working on
  logic [`NVPM_AW-1:0] nxt_idx; // Next copy word
  logic busy_ff; // Copy in progress, host shut out
  logic nxt_busy; // Next busy level
  logic nxt_recall_done; // Recall finishes this cycle
  logic nxt_store_done; // Store finishes this cycle

  // Read path registers and their next values
  logic [`NVPM_DW-1:0] rd_ff; // Read nibble shown on the bus
  logic [`NVPM_DW-1:0] nxt_rd; // Nibble for the next cycle
  logic oe_n_ff; // Device drives the bus when low
  logic nxt_oe_n; // Next drive enable

  // Decoded link conditions
  logic chip_sel; // Select qualified by strobe
  logic recall_req; // Initialize asks for a recall
  logic store_req; // Qualified store strobe
  logic rd_en; // Host read reaches the array
  logic wr_en; // Host write reaches the array
  logic [`NVPM_AW-1:0] addr; // Host word address

  // Copy datapath
  logic recall_wr; // Recall writes one volatile word
  logic prog_wr; // Store programs one backing word
  logic [`NVPM_DW-1:0] recall_word; // Word brought back by a recall

  // True on the final word of a copy; both copy states end on it
  function automatic logic nvpm_is_last(input logic [`NVPM_AW-1:0] a);
    return a == `NVPM_AW'(DEPTH - 1);
  endfunction

  // Address bits 1 to 8 pick the location; bit 8 also qualifies the store
  assign addr = link.latched_addr_bits;

  // Select and strobe must both be low before the array is touched
  assign chip_sel = !link.param_mem_select_n && !link.column_strobe_n;

  // Sequencer owns the array while busy, so host access waits
  assign rd_en = chip_sel && link.read_high && !busy_ff;
  assign wr_en = chip_sel && !link.read_high && !busy_ff;

  // Initialize is low active and wins over a store in the same cycle
  assign recall_req = !link.init_n;

  // Power-down blocks the strobe before it can start a copy
  assign store_req = !link.store_select_n && !link.latched_addr_bits[`NVPM_AW] && !link.power_down;

  // Copy strobes; a store stops writing the moment power-down is sensed
  assign recall_wr = (state_ff == NVPM_RECALL);
  assign prog_wr = (state_ff == NVPM_STORE) && !link.power_down;

  // An erased backing word recalls as the init word, never as garbage
  assign recall_word = nv_prog[idx_ff] ? nv_mem[idx_ff] : `NVPM_INIT_WORD;

  // Read answer: array word during an enabled read, init word otherwise
  assign nxt_rd = rd_en ? vol_mem[addr] : `NVPM_INIT_WORD;
  assign nxt_oe_n = !rd_en;

  // Link outputs, all straight from flip-flops; upper nibble held zero
  assign link.dev_data = {{(`NVPM_BUS_W-`NVPM_DW){1'b0}}, rd_ff};
  assign link.dev_data_oe_n = oe_n_ff;
  assign link.busy = busy_ff;

  // Next-state logic of the copy sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_busy = busy_ff;
    nxt_recall_done = 1'b0;
    nxt_store_done = 1'b0;
    case (state_ff)
      NVPM_IDLE: begin
        // Every copy starts from word zero
        nxt_idx = '0;
        if (recall_req) begin
          // Recall takes priority over a store requested in the same cycle
          nxt_state = NVPM_RECALL;
          nxt_busy = 1'b1;
        end else if (store_req) begin
          // Qualified strobe starts a full copy into the backing array
          nxt_state = NVPM_STORE;
          nxt_busy = 1'b1;
        end
      end
      NVPM_RECALL: begin
        // One word per clock, so a recall takes a fixed DEPTH cycles
        nxt_idx = idx_ff + `NVPM_AW'(1);
        if (nvpm_is_last(idx_ff)) begin
          nxt_state = NVPM_IDLE;
          nxt_busy = 1'b0;
          nxt_recall_done = 1'b1;
        end
      end
      NVPM_STORE: begin
        nxt_idx = idx_ff + `NVPM_AW'(1);
        // Power loss mid copy aborts; the words already written stay
        if (nvpm_is_last(idx_ff) || link.power_down) begin
          nxt_state = NVPM_IDLE;
          nxt_busy = 1'b0;
          // No done pulse for a cut store, so the host can tell
          nxt_store_done = !link.power_down;
        end
      end
      default: begin
        // Unreachable code; park in idle with the host let back in
        nxt_state = NVPM_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= NVPM_IDLE;
      idx_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      busy_ff <= nxt_busy;
    end
  end

  // Done pulses, each output from its own flip-flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      recall_done_ff <= 1'b0;
      store_done_ff <= 1'b0;
    end else begin
      recall_done_ff <= nxt_recall_done;
      store_done_ff <= nxt_store_done;
    end
  end

  // Volatile array: a recall owns it, otherwise host writes land here
  // No reset, as a real static array has none
  always_ff @(posedge sys_clk) begin
    if (recall_wr) begin
      vol_mem[idx_ff] <= recall_word;
    end else if (wr_en) begin
      // Host writes touch only the volatile copy until a store
      vol_mem[addr] <= link.host_data[`NVPM_DW-1:0];
    end
  end

  // Backing array: written only by a store, one word per clock
  always_ff @(posedge sys_clk) begin
    if (prog_wr) begin
      nv_mem[idx_ff] <= vol_mem[idx_ff];
    end
  end

  // Programmed flag per backing word. Reset stands for the erased part
  // as built; a real part keeps its contents across power cycles, so
  // rst is meant for build-up only and init for every later power-up.
  generate
    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_prog
      logic prog_ff; // This word holds a stored value
      logic hit; // The store is programming this word now
      assign hit = prog_wr && (idx_ff == `NVPM_AW'(gi));
      // Set once by a store, cleared only by build-up reset
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          prog_ff <= 1'b0;
        end else if (hit) begin
          prog_ff <= 1'b1;
        end
      end
      assign nv_prog[gi] = prog_ff;
    end
  endgenerate

  // Read path: answer one cycle after the select, for one cycle only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ff <= `NVPM_INIT_WORD;
      oe_n_ff <= 1'b1;
    end else begin
      rd_ff <= nxt_rd;
      oe_n_ff <= nxt_oe_n;
    end
  end

endmodule // nvpm_device

/* File: nvpm_host.sv */
// Processor end: drives select, strobe, address and data
`timescale 1ns/1ps
`include "nvpm_regs.svh"
module nvpm_host
  import nvpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  nvpm_if.host link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_store,
  input wire logic [`NVPM_AW-1:0] req_addr,
  input wire logic [`NVPM_DW-1:0] req_wdata,
  input wire logic power_down_in,
  input wire logic init_n_in,
  output logic req_ready_ff,
  output logic [`NVPM_DW-1:0] rdata_ff,
  output logic rdata_valid_ff
);
  logic sel_n_ff, cas_n_ff, store_n_ff, rd_ff;
  logic [`NVPM_AW:1] addr_ff;
  logic [`NVPM_DW-1:0] wd_ff;
  logic start;
  assign start = req_valid && req_ready_ff && !link.busy;
  assign link.param_mem_select_n = sel_n_ff;
  assign link.column_strobe_n = cas_n_ff;
  assign link.store_select_n = store_n_ff;
  assign link.read_high = rd_ff;
  assign link.latched_addr_bits = addr_ff;
  assign link.host_data = {{(`NVPM_BUS_W-`NVPM_DW){1'b0}}, wd_ff};
  assign link.power_down = power_down_in;
  assign link.init_n = init_n_in;
  // One cycle access: select and strobe low together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      store_n_ff <= 1'b1;
      rd_ff <= 1'b1;
      addr_ff <= '0;
      wd_ff <= '0;
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= !start;
      sel_n_ff <= !(start && !req_store);
      cas_n_ff <= !(start && !req_store);
      // Bit 8 held low during a store so the strobe qualifies
      store_n_ff <= !(start && req_store);
      rd_ff <= !(start && req_write);
      if (start) begin
        addr_ff <= req_store ? '0 : req_addr;
        wd_ff <= req_wdata;
      end
    end
  end
  // Capture nibble when the device enables its drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
      rdata_valid_ff <= 1'b0;
    end else begin
      rdata_valid_ff <= !link.dev_data_oe_n;
      if (!link.dev_data_oe_n) begin
        rdata_ff <= link.dev_data[`NVPM_DW-1:0];
      end
    end
  end
endmodule // nvpm_host

/* File: nvpm_chk.sv */
// Checker for the parameter memory link signals
`timescale 1ns/1ps
`include "nvpm_regs.svh"
module nvpm_chk (
  input logic sys_clk,
  input logic rst,
  input logic param_mem_select_n,
  input logic column_strobe_n,
  input logic store_select_n,
  input logic read_high,
  input logic [`NVPM_AW:1] latched_addr_bits,
  input logic [`NVPM_BUS_W-1:0] dev_data,
  input logic dev_data_oe_n,
  input logic power_down,
  input logic init_n,
  input logic busy
);
  // Read as seen on the wire
  wire rd_sel = !param_mem_select_n && !column_strobe_n && read_high;
  // Store the device must honour; recall wins over it
  wire st_go = !store_select_n && !latched_addr_bits[8] && !power_down && init_n && !busy;
  logic [8:0] busy_cnt_ff; // Length of the running copy
  wire [8:0] nxt_busy_cnt = busy ? busy_cnt_ff + 9'h001 : 9'h000;
  // Counter, not a repetition, since a copy is far longer than 8 cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy_cnt_ff <= 9'h000;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_CAUSE: assert property (!dev_data_oe_n |-> $past(rd_sel)) else $error("bus driven without read");
  AST_RD_ANSWER: assert property (rd_sel && !busy |=> !dev_data_oe_n) else $error("read not answered");
  AST_OE_ONE: assert property (!dev_data_oe_n |=> dev_data_oe_n) else $error("bus held too long");
  AST_HI_ZERO: assert property (!dev_data_oe_n |-> dev_data[7:4] == 4'h0) else $error("upper nibble set");
  AST_SEL_STROBE: assert property (!param_mem_select_n |-> !column_strobe_n ##1 column_strobe_n) else $error("select");
  AST_STORE_ADDR: assert property (!store_select_n |-> !latched_addr_bits[8]) else $error("store with bit8");
  AST_STORE_GO: assert property (st_go |=> busy) else $error("store not started");
  AST_PD_BLOCK: assert property (!store_select_n && power_down && init_n && !busy |=> !busy) else $error("pd store");
  AST_COPY_LEN: assert property ($fell(busy) && !power_down |-> busy_cnt_ff == 9'h100) else $error("copy length");
  C_READ: cover property (!dev_data_oe_n);
  C_STORE: cover property (st_go);
  C_RECALL: cover property ($fell(init_n));
endmodule // nvpm_chk

/* File: tb_nonvolatile_param_memory.sv */
// Testbench joining host and device ends
`timescale 1ns/1ps
`include "nvpm_regs.svh"
module tb_nonvolatile_param_memory;
  logic sys_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_store = 0, power_down_in = 0, init_n_in = 1;
  logic [7:0] req_addr = 8'h00;
  logic [3:0] req_wdata = 4'h0, rdata_ff;
  logic req_ready_ff, rdata_valid_ff, recall_done_ff, store_done_ff;
  int err_count = 0, tests_run = 0;
  nvpm_if i_nvpm_if ();
  nvpm_device i_nvpm_device (.sys_clk(sys_clk), .rst(rst), .link(i_nvpm_if), .recall_done_ff(recall_done_ff),
    .store_done_ff(store_done_ff));
  nvpm_host i_nvpm_host (.sys_clk(sys_clk), .rst(rst), .link(i_nvpm_if), .req_valid(req_valid), .req_write(req_write),
    .req_store(req_store), .req_addr(req_addr), .req_wdata(req_wdata), .power_down_in(power_down_in),
    .init_n_in(init_n_in), .req_ready_ff(req_ready_ff), .rdata_ff(rdata_ff), .rdata_valid_ff(rdata_valid_ff));
  nvpm_chk i_nvpm_chk (.sys_clk(sys_clk), .rst(rst), .param_mem_select_n(i_nvpm_if.param_mem_select_n),
    .column_strobe_n(i_nvpm_if.column_strobe_n), .store_select_n(i_nvpm_if.store_select_n),
    .read_high(i_nvpm_if.read_high), .latched_addr_bits(i_nvpm_if.latched_addr_bits),
    .dev_data(i_nvpm_if.dev_data), .dev_data_oe_n(i_nvpm_if.dev_data_oe_n), .power_down(i_nvpm_if.power_down),
    .init_n(i_nvpm_if.init_n), .busy(i_nvpm_if.busy));
  always #10 sys_clk = ~sys_clk;
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Stored pattern, derived from the address alone
  function logic [3:0] pat(input logic [7:0] a);
    return a[3:0] ^ a[7:4];
  endfunction
  // One request, issued only when the host is ready and no copy runs
  task req(input logic w, s, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (!(req_ready_ff === 1'b1 && i_nvpm_if.busy === 1'b0) && n < 600);
    if (n >= 600) chk(8'hEE, 8'h00);
    if (n >= 600) test_done;
    @(posedge sys_clk);
    {req_valid, req_write, req_store, req_addr, req_wdata} <= {1'b1, w, s, a, d};
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [3:0] e);
    int n;
    req(1'b0, 1'b0, a, 4'h0);
    n = 0;
    do begin @(negedge sys_clk); n++; end while (rdata_valid_ff !== 1'b1 && n < 20);
    if (n >= 20) chk(8'hEE, 8'h00);
    if (n >= 20) test_done;
    chk({4'h0, rdata_ff}, {4'h0, e});
  endtask
  // Waits out a whole copy and expects its done pulse as busy falls
  task copy_wait(input logic st);
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (i_nvpm_if.busy !== 1'b1 && n < 10);
    while (i_nvpm_if.busy !== 1'b0 && n < 600) begin @(negedge sys_clk); n++; end
    if (n >= 600) chk(8'hEE, 8'h00);
    if (n >= 600) test_done;
    chk({7'h0, st ? store_done_ff : recall_done_ff}, 8'h01);
  endtask
  task recall;
    @(posedge sys_clk) init_n_in <= 1'b0;
    @(posedge sys_clk) init_n_in <= 1'b1;
    copy_wait(1'b0);
  endtask
  task t_blank;
    recall;
    rd(8'h00, `NVPM_INIT_WORD);
    rd(8'hFF, `NVPM_INIT_WORD);
    $display("t_blank done");
  endtask
  task t_wr_rd;
    for (int i = 0; i < 256; i++) req(1'b1, 1'b0, i[7:0], pat(i[7:0]));
    for (int i = 0; i < 256; i++) rd(i[7:0], pat(i[7:0]));
    $display("t_wr_rd done");
  endtask
  // Store, then scribble, then recall: the stored copy must come back
  task t_store;
    req(1'b0, 1'b1, 8'h00, 4'h0);
    copy_wait(1'b1);
    for (int i = 0; i < 256; i += 17) req(1'b1, 1'b0, i[7:0], ~pat(i[7:0]));
    rd(8'h11, ~pat(8'h11));
    recall;
    for (int i = 0; i < 256; i += 17) rd(i[7:0], pat(i[7:0]));
    $display("t_store done");
  endtask
  task t_pd;
    @(posedge sys_clk) power_down_in <= 1'b1;
    req(1'b1, 1'b0, 8'h03, 4'h5);
    rd(8'h03, 4'h5);
    req(1'b0, 1'b1, 8'h00, 4'h0);
    repeat (8) @(negedge sys_clk);
    chk({7'h0, i_nvpm_if.busy}, 8'h00);
    @(posedge sys_clk) power_down_in <= 1'b0;
    recall;
    rd(8'h03, pat(8'h03));
    $display("t_pd done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_blank;
    t_wr_rd;
    t_store;
    t_pd;
    test_done;
  end
endmodule // tb_nonvolatile_param_memory
